// ---- verilog/pfr_pkg.sv ----
// shared constants, encodings and carrier structs of the fault reporting unit
package pfr_pkg;
    // ----------------------------------------------------------------
    // vectors and error code layout
    // ----------------------------------------------------------------
    localparam logic [7:0] PFR_VEC_PAGE = 8'h0e;
    localparam logic [7:0] PFR_VEC_FP = 8'h10;
    localparam int PFR_EC_W = 32;
    localparam int PFR_EC_P = 0;
    localparam int PFR_EC_WR = 1;
    localparam int PFR_EC_US = 2;
    localparam int PFR_EC_RESV = 3;
    // ----------------------------------------------------------------
    // control bits, floating-point flags, reset values
    // ----------------------------------------------------------------
    localparam int PFR_CTL_W = 4;
    localparam int PFR_CTL_PAGING = 0;
    localparam int PFR_CTL_NUMERR = 1;
    localparam int PFR_CTL_LGPAGE = 2;
    localparam int PFR_CTL_ADDREXT = 3;
    localparam int PFR_FP_CLS = 6;
    localparam int PFR_FP_FLG = 8;
    localparam int PFR_FP_STK = 6;
    localparam int PFR_FP_ARI = 7;
    localparam logic [PFR_CTL_W-1:0] PFR_CTRL_RST = 4'h0;
    localparam logic [PFR_FP_CLS-1:0] PFR_MASK_RST = 6'h3f;
    localparam logic [PFR_FP_FLG-1:0] PFR_FLAGS_RST = 8'h00;
    // ----------------------------------------------------------------
    // register map, byte addresses
    // ----------------------------------------------------------------
    localparam int PFR_AW = 8;
    localparam logic [PFR_AW-1:0] PFR_OFF_CTRL = 8'h00;
    localparam logic [PFR_AW-1:0] PFR_OFF_FLA = 8'h04;
    localparam logic [PFR_AW-1:0] PFR_OFF_ERRC = 8'h08;
    localparam logic [PFR_AW-1:0] PFR_OFF_SIP = 8'h0c;
    localparam logic [PFR_AW-1:0] PFR_OFF_FPST = 8'h10;
    localparam logic [PFR_AW-1:0] PFR_OFF_FPMSK = 8'h14;
    localparam logic [PFR_AW-1:0] PFR_OFF_FPIP = 8'h18;
    localparam logic [PFR_AW-1:0] PFR_OFF_LVEC = 8'h1c;
    localparam logic [1:0] PFR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PFR_RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PFR_TS_NONE = 2'h0,
        PFR_TS_OLD = 2'h1,
        PFR_TS_NEW_PRE = 2'h2,
        PFR_TS_NEW_POST = 2'h3
    } pfr_ts_e;
    typedef enum logic [1:0] {
        PFR_ST_IDLE = 2'h1,
        PFR_ST_LOAD = 2'h2
    } pfr_st_e;
    typedef struct packed {
        logic valid;
        logic [31:0] lin_addr;
        logic write;
        logic user;
        logic pde_present;
        logic pte_present;
        logic priv_ok;
        logic rw_violation;
        logic resv_hit;
        pfr_ts_e ts_phase;
    } pfr_walk_s;
    typedef struct packed {
        logic valid;
        logic [PFR_FP_CLS-1:0] cls;
        logic stack_sub;
        logic arith_sub;
        logic [31:0] instr_ip;
    } pfr_fperr_s;
    typedef struct packed {
        logic valid;
        logic waiting;
        logic [31:0] ip;
    } pfr_fpins_s;
    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic code_valid;
        logic [PFR_EC_W-1:0] code;
        logic [31:0] saved_ip;
    } pfr_exc_s;
endpackage

// ---- verilog/pfr_fault_unit.sv ----
// page fault and deferred floating-point error reporting with axi4-lite registers
`timescale 1ns/1ps
// Contract
// - page fault raised only with paging enabled, on a not-present entry
// - page fault raised when access lacks privilege for the page
// - error code present bit: 0 not present, 1 rights or reserved violation
// - error code write bit: 0 read, 1 write
// - error code user bit: 1 user mode, 0 supervisor mode
// - reserved-bit flag set only while large-page or address-extension enabled
// - every page fault loads the full faulting linear address
// - protection violation still marks directory entry accessed and dirty
// - table entry accessed only without violation or on read/write violation
// - saved pointer is faulting instruction, except new-task switch cases
// - faulting instruction is not executed; state left restartable
// - faults reading new task segment or table use new task context
// - before commit change nothing; after commit load new state, then fault
// - floating-point error exception vector 16 only with report enable
// - six error classes with subtypes, each with status flag and mask
// - masked error gives default result and continues without exception
// - unmasked error sets flag, raises exception at next waiting instruction
// - all but the no-wait control forms check pending errors first
// - saved pointer is the waiting instruction; fp pointer holds faulting one
// - floating-point error exception pushes no error code
module pfr_fault_unit
    import pfr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PFR_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PFR_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pfr_walk_s walk,
    input wire logic [31:0] cur_ip,
    input wire logic [31:0] new_task_ip,
    input wire pfr_fperr_s fp_err,
    input wire pfr_fpins_s fp_instr,
    output pfr_exc_s exc,
    output logic pde_mark_ad,
    output logic pte_mark_a,
    output logic load_new_task,
    output logic fp_default_result,
    output logic fp_instr_go
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pfr_st_e st;
        logic [PFR_CTL_W-1:0] ctrl;
        logic [PFR_FP_CLS-1:0] mask;
        logic [PFR_FP_FLG-1:0] flags;
        logic [31:0] fault_addr;
        logic [PFR_EC_W-1:0] err_code;
        logic [31:0] saved_ip;
        logic [31:0] fp_ip;
        logic [7:0] last_vec;
        logic [PFR_EC_W-1:0] pend_code;
        logic [31:0] pend_ip;
        pfr_exc_s exc;
        logic pde_mark;
        logic pte_mark;
        logic load_new;
        logic fp_dflt;
        logic fp_go;
        logic aw_got;
        logic [PFR_AW-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pfr_state_s;

    pfr_state_s r;
    pfr_state_s n;
    logic c_pf;
    logic not_present;
    logic prot;
    logic resv_eff;
    logic fp_pending;
    logic [PFR_EC_W-1:0] code_now;

    function automatic logic hit(input logic [PFR_AW-1:0] a, input logic [PFR_AW-1:0] off);
        hit = ({a[PFR_AW-1:2], 2'h0} == off);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        n.exc.valid = 1'b0;
        n.pde_mark = 1'b0;
        n.pte_mark = 1'b0;
        n.load_new = 1'b0;
        n.fp_dflt = 1'b0;
        n.fp_go = 1'b0;
        // entry further down is meaningless once an upper entry is absent
        not_present = !walk.pde_present || !walk.pte_present;
        prot = !walk.priv_ok && !not_present;
        resv_eff = walk.resv_hit && !not_present
            && (r.ctrl[PFR_CTL_LGPAGE] || r.ctrl[PFR_CTL_ADDREXT]);
        c_pf = walk.valid && r.ctrl[PFR_CTL_PAGING] && (r.st == PFR_ST_IDLE)
            && (not_present || prot || resv_eff);
        code_now = '0;
        code_now[PFR_EC_P] = !not_present;
        code_now[PFR_EC_WR] = walk.write;
        code_now[PFR_EC_US] = walk.user;
        code_now[PFR_EC_RESV] = resv_eff;
        fp_pending = r.ctrl[PFR_CTL_NUMERR] && |(r.flags[PFR_FP_CLS-1:0] & ~r.mask);

        // accessed and dirty marking happens whether or not the walk faults
        if (walk.valid && r.ctrl[PFR_CTL_PAGING] && (r.st == PFR_ST_IDLE)) begin
            n.pde_mark = walk.pde_present && !resv_eff;
            n.pte_mark = !not_present && !resv_eff && (!prot || walk.rw_violation);
        end

        case (r.st)
            PFR_ST_IDLE: begin
                if (c_pf) begin
                    n.fault_addr = walk.lin_addr;
                    n.err_code = code_now;
                    if (walk.ts_phase == PFR_TS_NEW_POST) begin
                        // new task state goes in unchecked before the fault is taken
                        n.st = PFR_ST_LOAD;
                        n.load_new = 1'b1;
                        n.pend_code = code_now;
                        n.pend_ip = new_task_ip;
                    end else begin
                        // exc marks the instruction squashed, nothing else commits
                        n.exc.valid = 1'b1;
                        n.exc.vector = PFR_VEC_PAGE;
                        n.exc.code_valid = 1'b1;
                        n.exc.code = code_now;
                        n.exc.saved_ip = (walk.ts_phase == PFR_TS_NEW_PRE) ?
                            new_task_ip : cur_ip;
                        n.saved_ip = n.exc.saved_ip;
                        n.last_vec = PFR_VEC_PAGE;
                    end
                end else if (fp_instr.valid) begin
                    if (fp_instr.waiting && fp_pending) begin
                        n.exc.valid = 1'b1;
                        n.exc.vector = PFR_VEC_FP;
                        n.exc.code_valid = 1'b0;
                        n.exc.code = '0;
                        n.exc.saved_ip = fp_instr.ip;
                        n.saved_ip = fp_instr.ip;
                        n.last_vec = PFR_VEC_FP;
                    end else begin
                        n.fp_go = 1'b1;
                    end
                end
            end
            PFR_ST_LOAD: begin
                n.exc.valid = 1'b1;
                n.exc.vector = PFR_VEC_PAGE;
                n.exc.code_valid = 1'b1;
                n.exc.code = r.pend_code;
                n.exc.saved_ip = r.pend_ip;
                n.saved_ip = r.pend_ip;
                n.last_vec = PFR_VEC_PAGE;
                n.st = PFR_ST_IDLE;
            end
            default: begin
                n.st = PFR_ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // axi4-lite slave
        // ------------------------------------------------------------
        if (s_axi_awvalid && r.awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = PFR_RESP_OKAY;
            if (hit(r.aw_addr, PFR_OFF_CTRL)) begin
                if (r.w_strb[0]) begin
                    n.ctrl = r.w_data[PFR_CTL_W-1:0];
                end
            end else if (hit(r.aw_addr, PFR_OFF_FPMSK)) begin
                if (r.w_strb[0]) begin
                    n.mask = r.w_data[PFR_FP_CLS-1:0];
                end
            end else if (hit(r.aw_addr, PFR_OFF_FPST)) begin
                if (r.w_strb[0]) begin
                    n.flags = r.flags & ~r.w_data[PFR_FP_FLG-1:0];
                end
            end else if (!(hit(r.aw_addr, PFR_OFF_FLA) || hit(r.aw_addr, PFR_OFF_ERRC)
                || hit(r.aw_addr, PFR_OFF_SIP) || hit(r.aw_addr, PFR_OFF_FPIP)
                || hit(r.aw_addr, PFR_OFF_LVEC))) begin
                n.bresp = PFR_RESP_SLVERR;
            end
        end

        // floating-point error capture after the clear, so a new error wins
        if (fp_err.valid && (fp_err.cls != '0)) begin
            n.flags = n.flags | {fp_err.arith_sub, fp_err.stack_sub, fp_err.cls};
            n.fp_ip = fp_err.instr_ip;
            n.fp_dflt = ((fp_err.cls & ~r.mask) == '0);
        end

        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready) begin
            n.rvalid = 1'b1;
            n.rresp = PFR_RESP_OKAY;
            n.rdata = '0;
            if (hit(s_axi_araddr, PFR_OFF_CTRL)) begin
                n.rdata[PFR_CTL_W-1:0] = r.ctrl;
            end else if (hit(s_axi_araddr, PFR_OFF_FLA)) begin
                n.rdata = r.fault_addr;
            end else if (hit(s_axi_araddr, PFR_OFF_ERRC)) begin
                n.rdata = r.err_code;
            end else if (hit(s_axi_araddr, PFR_OFF_SIP)) begin
                n.rdata = r.saved_ip;
            end else if (hit(s_axi_araddr, PFR_OFF_FPST)) begin
                n.rdata[PFR_FP_FLG-1:0] = r.flags;
            end else if (hit(s_axi_araddr, PFR_OFF_FPMSK)) begin
                n.rdata[PFR_FP_CLS-1:0] = r.mask;
            end else if (hit(s_axi_araddr, PFR_OFF_FPIP)) begin
                n.rdata = r.fp_ip;
            end else if (hit(s_axi_araddr, PFR_OFF_LVEC)) begin
                n.rdata[7:0] = r.last_vec;
            end else begin
                n.rresp = PFR_RESP_SLVERR;
            end
        end
        // one write and one read in flight; ready lowers once a slot is held
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= PFR_ST_IDLE;
            r.ctrl <= PFR_CTRL_RST;
            r.mask <= PFR_MASK_RST;
            r.flags <= PFR_FLAGS_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign exc = r.exc;
    assign pde_mark_ad = r.pde_mark;
    assign pte_mark_a = r.pte_mark;
    assign load_new_task = r.load_new;
    assign fp_default_result = r.fp_dflt;
    assign fp_instr_go = r.fp_go;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic c_pf_d;
    logic [31:0] walk_addr_d;
    always_ff @(posedge aclk) begin
        c_pf_d <= c_pf;
        walk_addr_d <= walk.lin_addr;
    end

    paging_gate_a: assert property (walk.valid && !r.ctrl[PFR_CTL_PAGING] && !fp_instr.valid
        && r.st == PFR_ST_IDLE |=> !exc.valid)
        else $error("page fault raised with paging off");
    priv_fault_a: assert property (walk.valid && r.ctrl[PFR_CTL_PAGING] && r.st == PFR_ST_IDLE
        && walk.pde_present && walk.pte_present && !walk.priv_ok
        && walk.ts_phase != PFR_TS_NEW_POST
        |=> exc.valid && exc.vector == PFR_VEC_PAGE && exc.code[PFR_EC_P])
        else $error("privilege violation missed");
    np_code_a: assert property (c_pf && !walk.pde_present && walk.ts_phase != PFR_TS_NEW_POST
        |=> exc.valid && !exc.code[PFR_EC_P])
        else $error("not-present code wrong");
    wr_flag_a: assert property (c_pf && walk.ts_phase != PFR_TS_NEW_POST
        |=> exc.code[PFR_EC_WR] == $past(walk.write))
        else $error("write flag wrong");
    us_flag_a: assert property (c_pf && walk.ts_phase != PFR_TS_NEW_POST
        |=> exc.code[PFR_EC_US] == $past(walk.user))
        else $error("user flag wrong");
    resv_gate_a: assert property (exc.valid && exc.code[PFR_EC_RESV]
        |-> r.ctrl[PFR_CTL_LGPAGE] || r.ctrl[PFR_CTL_ADDREXT] || $past(r.ctrl[PFR_CTL_LGPAGE])
        || $past(r.ctrl[PFR_CTL_ADDREXT]))
        else $error("reserved flag without extension");
    code_zero_a: assert property (exc.valid && exc.vector == PFR_VEC_PAGE
        |-> exc.code[PFR_EC_W-1:PFR_EC_RESV+1] == '0)
        else $error("upper code bits set");
    fla_load_a: assert property (c_pf_d |-> r.fault_addr == walk_addr_d)
        else $error("fault address not loaded");
    pde_mark_a: assert property (walk.valid && r.ctrl[PFR_CTL_PAGING] && r.st == PFR_ST_IDLE
        && walk.pde_present && walk.pte_present && !walk.priv_ok && !walk.resv_hit
        |=> pde_mark_ad)
        else $error("directory entry not marked");
    pte_block_a: assert property (walk.valid && !walk.priv_ok && !walk.rw_violation
        |=> !pte_mark_a)
        else $error("table entry marked on violation");
    old_ip_a: assert property (c_pf && walk.ts_phase inside {PFR_TS_NONE, PFR_TS_OLD}
        |=> exc.saved_ip == $past(cur_ip))
        else $error("saved pointer not faulting instruction");
    new_pre_a: assert property (c_pf && walk.ts_phase == PFR_TS_NEW_PRE
        |=> exc.valid && !load_new_task && exc.saved_ip == $past(new_task_ip))
        else $error("new-context fault pointer wrong");
    post_commit_a: assert property (c_pf && walk.ts_phase == PFR_TS_NEW_POST
        |=> load_new_task && !exc.valid ##1 exc.valid
        && exc.saved_ip == $past(new_task_ip, 2))
        else $error("post-commit order wrong");
    fp_enable_a: assert property (exc.valid && exc.vector == PFR_VEC_FP
        |-> $past(r.ctrl[PFR_CTL_NUMERR]))
        else $error("fp exception with reporting off");
    masked_a: assert property (fp_err.valid && fp_err.cls != '0
        && (fp_err.cls & ~r.mask) == '0 |=> fp_default_result)
        else $error("masked error gave no default");
    fp_raise_a: assert property (fp_instr.valid && fp_instr.waiting && fp_pending && !c_pf
        && r.st == PFR_ST_IDLE |=> exc.valid && !fp_instr_go
        && exc.saved_ip == $past(fp_instr.ip))
        else $error("pending error not raised");
    nowait_a: assert property (fp_instr.valid && !fp_instr.waiting && !c_pf
        && r.st == PFR_ST_IDLE |=> fp_instr_go && !exc.valid)
        else $error("no-wait form was blocked");
    fp_nocode_a: assert property (exc.valid && exc.vector == PFR_VEC_FP
        |-> !exc.code_valid && exc.code == '0)
        else $error("fp exception carried a code");
    flag_set_a: assert property (fp_err.valid |=> (r.flags[PFR_FP_CLS-1:0]
        & $past(fp_err.cls)) == $past(fp_err.cls))
        else $error("error flag not set");

    pf_np_c: cover property (c_pf && !walk.pte_present);
    pf_post_c: cover property (c_pf && walk.ts_phase == PFR_TS_NEW_POST ##2 exc.valid);
    fp_exc_c: cover property (exc.valid && exc.vector == PFR_VEC_FP);
    fp_dflt_c: cover property (fp_default_result);
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the page and floating-point fault reporting unit
`timescale 1ns/1ps
module tb;
    import pfr_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [PFR_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, cur_ip, new_task_ip;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic pde_mark_ad, pte_mark_a, load_new_task, fp_default_result, fp_instr_go;
    pfr_walk_s walk;
    pfr_fperr_s fp_err;
    pfr_fpins_s fp_instr;
    pfr_exc_s exc;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    pfr_fault_unit u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .walk, .cur_ip, .new_task_ip, .fp_err,
        .fp_instr, .exc, .pde_mark_ad, .pte_mark_a, .load_new_task, .fp_default_result,
        .fp_instr_go);
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic fin;
        fin = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                fin = 1'b1;
                s_axi_bready <= 1'b0;
                chk("bresp", er, s_axi_bresp);
            end
        end
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!s_axi_rvalid) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    // one translation result; expected fault, code and markings given by the caller
    task automatic xlate(input logic [31:0] la, input logic w, u, pd, pt, ok, rv, rs,
        input pfr_ts_e ts, input logic fx, input logic [3:0] code, input logic ad, ta);
        logic nt;
        nt = (ts == PFR_TS_NEW_PRE) || (ts == PFR_TS_NEW_POST);
        @(posedge aclk);
        walk <= '{1'b1, la, w, u, pd, pt, ok, rv, rs, ts};
        @(posedge aclk);
        walk.valid <= 1'b0;
        #1;
        chk("load_new_task", ts == PFR_TS_NEW_POST, load_new_task);
        if (ts == PFR_TS_NEW_POST) begin
            chk("exc_early", 1'b0, exc.valid);
            @(posedge aclk);
            #1;
        end else begin
            chk("pde_mark_ad", ad, pde_mark_ad);
            chk("pte_mark_a", ta, pte_mark_a);
        end
        chk("exc_valid", fx, exc.valid);
        if (fx) begin
            chk("vector", PFR_VEC_PAGE, exc.vector);
            chk("code_valid", 1'b1, exc.code_valid);
            chk("code", {28'h0, code}, exc.code);
            chk("saved_ip", nt ? new_task_ip : cur_ip, exc.saved_ip);
        end
    endtask
    task automatic fpe(input logic [5:0] c, input logic st, input logic [31:0] ip,
        input logic dflt);
        @(posedge aclk);
        fp_err <= '{1'b1, c, st, ~st, ip};
        @(posedge aclk);
        fp_err.valid <= 1'b0;
        #1;
        chk("fp_default_result", dflt, fp_default_result);
    endtask
    task automatic fpi(input logic wt, input logic [31:0] ip, input logic go, ex);
        @(posedge aclk);
        fp_instr <= '{1'b1, wt, ip};
        @(posedge aclk);
        fp_instr.valid <= 1'b0;
        #1;
        chk("fp_instr_go", go, fp_instr_go);
        chk("fp_exc", ex, exc.valid);
        if (ex) begin
            chk("fp_vector", PFR_VEC_FP, exc.vector);
            chk("fp_code", 32'h0, exc.code);
            chk("fp_code_valid", 32'h0, {31'h0, exc.code_valid});
            chk("fp_saved_ip", ip, exc.saved_ip);
        end
    endtask
    // ----------------------------------------------------------------
    // clock, reset, timeout and sequence
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        cur_ip = 32'h0000_1000;
        new_task_ip = 32'h0000_2000;
        walk = '0;
        fp_err = '0;
        fp_instr = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(PFR_OFF_CTRL, 32'h0, PFR_RESP_OKAY);
        axr(PFR_OFF_FPMSK, 32'h3f, PFR_RESP_OKAY);
        axr(8'h20, 32'h0, PFR_RESP_SLVERR);
        axw(8'h20, 32'h1, PFR_RESP_SLVERR);
        axw(PFR_OFF_FLA, 32'h55, PFR_RESP_OKAY);
        axr(PFR_OFF_FLA, 32'h0, PFR_RESP_OKAY);
        xlate(32'h1234_5678, 1, 1, 0, 0, 1, 0, 0, PFR_TS_NONE, 0, 4'h0, 0, 0);
        axw(PFR_OFF_CTRL, 32'h3, PFR_RESP_OKAY);
        xlate(32'hdead_beef, 1, 1, 0, 0, 1, 0, 0, PFR_TS_NONE, 1, 4'h6, 0, 0);
        axr(PFR_OFF_FLA, 32'hdead_beef, PFR_RESP_OKAY);
        axr(PFR_OFF_ERRC, 32'h6, PFR_RESP_OKAY);
        xlate(32'h0040_0000, 0, 0, 1, 0, 1, 0, 0, PFR_TS_OLD, 1, 4'h0, 1, 0);
        xlate(32'h0080_1004, 0, 1, 1, 1, 0, 1, 0, PFR_TS_NONE, 1, 4'h5, 1, 1);
        xlate(32'h0080_2008, 1, 0, 1, 1, 0, 0, 0, PFR_TS_NONE, 1, 4'h3, 1, 0);
        xlate(32'hffff_fffc, 1, 0, 1, 1, 1, 0, 0, PFR_TS_NONE, 0, 4'h0, 1, 1);
        axr(PFR_OFF_FLA, 32'h0080_2008, PFR_RESP_OKAY);
        axw(PFR_OFF_CTRL, 32'h7, PFR_RESP_OKAY);
        xlate(32'h0000_0ffc, 0, 1, 1, 1, 1, 0, 1, PFR_TS_NONE, 1, 4'hd, 0, 0);
        xlate(32'h0100_0000, 0, 0, 0, 0, 1, 0, 0, PFR_TS_NEW_PRE, 1, 4'h0, 0, 0);
        xlate(32'h0200_0000, 1, 0, 1, 0, 1, 0, 0, PFR_TS_NEW_POST, 1, 4'h2, 0, 0);
        fpe(6'h01, 0, 32'h0000_3000, 1);
        fpi(1, 32'h0000_3004, 1, 0);
        axr(PFR_OFF_FPST, 32'h81, PFR_RESP_OKAY);
        axw(PFR_OFF_FPST, 32'hff, PFR_RESP_OKAY);
        axw(PFR_OFF_FPMSK, 32'h0, PFR_RESP_OKAY);
        fpe(6'h04, 1, 32'h0000_3100, 0);
        fpi(0, 32'h0000_3104, 1, 0);
        fpi(1, 32'h0000_3108, 0, 1);
        axr(PFR_OFF_FPIP, 32'h0000_3100, PFR_RESP_OKAY);
        axr(PFR_OFF_FPST, 32'h44, PFR_RESP_OKAY);
        axw(PFR_OFF_CTRL, 32'h1, PFR_RESP_OKAY);
        fpi(1, 32'h0000_310c, 1, 0);
        conclude();
    end
endmodule
